/* File: fasc_defines.svh */
// Register offsets, field positions, reset values and timing counts for the flow alarm block
`ifndef FASC_DEFINES_SVH
`define FASC_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FASC_REG_CTRL 8'h00
`define FASC_REG_ALM_EN 8'h04
`define FASC_REG_LATCH_EN 8'h08
`define FASC_REG_FLOW1 8'h0C
`define FASC_REG_FLOW2 8'h10
`define FASC_REG_NOFLOW 8'h14
`define FASC_REG_DEV 8'h18
`define FASC_REG_TEMP 8'h1C
`define FASC_REG_VALVE 8'h20
`define FASC_REG_CAL_HRS 8'h24
`define FASC_REG_OVH_HRS 8'h28
`define FASC_REG_SP 8'h2C
`define FASC_REG_CUTOFF 8'h30
`define FASC_REG_PAGE 8'h34
`define FASC_REG_PAGE_MASK 8'h38
`define FASC_REG_STATUS 8'h3C
`define FASC_REG_ALM_CLR 8'h40
`define FASC_REG_EXT_ERR 8'h44
`define FASC_REG_TOTAL 8'h48
`define FASC_REG_FLOW_SP 8'h4C
// ----------------------------------------
// Fields and alarm indices
// ----------------------------------------
`define FASC_CTRL_UNIT 0
`define FASC_CTRL_RAMP 1
`define FASC_CTRL_ZSP_INH 2
`define FASC_CTRL_SP_ANALOG 3
`define FASC_NALM 10
`define FASC_ALM_OVF 5
`define FASC_ALARM_CODES 40'h12367789AB
`define FASC_EXT_ERR_PAGE 32'h00000400
// ----------------------------------------
// Reset values, flow in hundredths of a percent of full scale
// ----------------------------------------
`define FASC_RST_ALM_EN 10'h3FF
`define FASC_RST_FLOW1 32'h27100000
`define FASC_RST_FLOW2 32'hFFFF0000
`define FASC_NOFLOW_MAX 16'h00C8
`define FASC_RST_DEV 32'h03E80AF6
`define FASC_RST_TEMP 32'h003C0005
`define FASC_RST_VALVE 32'h26AC0000
`define FASC_RST_HOURS 16'h2238
`define FASC_OVH_FLOW_MIN 16'h0032
`define FASC_RST_PAGE 3'h1
`define FASC_NPAGE 3'h6
// ----------------------------------------
// Timing
// ----------------------------------------
`define FASC_CLK_NS 4
`define FASC_TICK_NS 1000000
`define FASC_TICKS_PER_S 1000
`define FASC_PAGE_HOLD_S 3
`define FASC_NV_SAVE_S 5
`define FASC_HOUR_S 3600
`endif

/* File: fasc_host_model.sv */
// Host side register master for the flow alarm block
`timescale 1ns/100ps
`default_nettype none
module fasc_host_model (
	input wire logic clk_i,
	output logic [7:0] addr_o,
	output logic [31:0] data_o,
	output logic awv_o,
	output logic wv_o,
	output logic bry_o,
	output logic arv_o,
	output logic rry_o,
	input wire logic awr_i,
	input wire logic wr_i,
	input wire logic bv_i,
	input wire logic [1:0] br_i,
	input wire logic arr_i,
	input wire logic rv_i,
	input wire logic [31:0] rd_i,
	input wire logic [1:0] rr_i
);
	initial {addr_o, data_o, awv_o, wv_o, bry_o, arv_o, rry_o} = '0;
	// One access at a time; address lines are shared by both directions
	task automatic acc(input logic w, input logic [7:0] a, inout logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge clk_i);
		addr_o <= a;
		data_o <= d;
		awv_o <= w;
		wv_o <= w;
		bry_o <= w;
		arv_o <= !w;
		rry_o <= !w;
		for (n = 0; n < 99; n++) begin
			@(posedge clk_i);
			if (awr_i) awv_o <= 1'b0;
			if (wr_i) wv_o <= 1'b0;
			if (arr_i) arv_o <= 1'b0;
			if (w ? bv_i : rv_i) break;
		end
		r = w ? br_i : rr_i;
		if (!w) d = rd_i;
		bry_o <= 1'b0;
		rry_o <= 1'b0;
		if (n == 99) testbench.stop_test(1);
	endtask : acc
endmodule : fasc_host_model
`default_nettype wire

/* File: fasc_page_sel.sv */
// Aux voltage page decoder with hold-time filter
`timescale 1ns/100ps
`default_nettype none
`include "fasc_defines.svh"
module fasc_page_sel (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	input wire logic [13:0] aux_mv_i,
	output logic req_o,
	output logic [2:0] page_o
);
	localparam logic [15:0] HOLD = 16'(`FASC_PAGE_HOLD_S * `FASC_TICKS_PER_S);
	logic [2:0] dec;
	logic [2:0] cand_q;
	logic [15:0] cnt_q;
	// ----------------------------------------
	// Voltage bands, millivolts
	// ----------------------------------------
	always_comb begin
		dec = 3'h0;
		if (aux_mv_i >= 14'h0064 && aux_mv_i < 14'h03E8) dec = 3'h1;
		else if (aux_mv_i >= 14'h03E8 && aux_mv_i < 14'h07D0) dec = 3'h2;
		else if (aux_mv_i >= 14'h07D0 && aux_mv_i < 14'h0BB8) dec = 3'h3;
		else if (aux_mv_i >= 14'h0BB8 && aux_mv_i < 14'h0FA0) dec = 3'h4;
		else if (aux_mv_i >= 14'h0FA0 && aux_mv_i < 14'h1194) dec = 3'h5;
		else if (aux_mv_i >= 14'h1194 && aux_mv_i <= 14'h1388) dec = 3'h6;
	end
	// Level must stay changed past the hold time before it counts
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cand_q <= 3'h0;
			cnt_q <= 16'h0000;
			page_o <= 3'h0;
			req_o <= 1'b0;
		end else begin
			req_o <= 1'b0;
			if (dec != cand_q) begin
				cand_q <= dec;
				cnt_q <= 16'h0000;
			end else if (cand_q != page_o && tick_i) begin
				if (cnt_q > HOLD) begin
					page_o <= cand_q;
					req_o <= 1'b1;
					cnt_q <= 16'h0000;
				end else begin
					cnt_q <= cnt_q + 16'h0001;
				end
			end
		end
	end
endmodule : fasc_page_sel
`default_nettype wire

/* File: fasc_pkg.sv */
// Types shared by the flow alarm block
package fasc_pkg;
	typedef struct packed {
		logic [15:0] hi;
		logic [15:0] lo;
	} fasc_lim_t;
	typedef enum logic {
		FASC_RAMP_OFF = 1'b0,
		FASC_RAMP_TIME = 1'b1
	} fasc_ramp_t;
endpackage : fasc_pkg

/* File: fasc_properties.sv */
// Port checks for the flow alarm block
`timescale 1ns/100ps
`default_nettype none
module fasc_properties #(
	parameter int unsigned TICK_CYCLES = 10,
	parameter int unsigned HOUR_TICKS = 20
) (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic nv_wr_o,
	input wire logic [2:0] page_o,
	input wire logic alarm_o,
	input wire logic [3:0] alarm_code_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	wr_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
		else $error("write response not two cycles after request");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data late");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
		else $error("read data changed while waiting");
	slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == '0)
		else $error("refused read returned data");
	alarm_code_a: assert property (alarm_o == (alarm_code_o != 4'h0))
		else $error("alarm flag and code disagree");
	code_set_a: assert property (!(alarm_code_o inside {4'h4, 4'h5, [4'hC:4'hF]}))
		else $error("unused alarm code shown");
	save_pulse_a: assert property (nv_wr_o |=> !nv_wr_o)
		else $error("save request longer than one cycle");
	page_range_a: assert property (page_o inside {[3'h1:3'h6]})
		else $error("no valid page active");
endmodule : fasc_properties
`default_nettype wire

/* File: fasc_top.sv */
// Flow alarms, page select and setpoint conditioning with an AXI4-Lite register slave
//
// Summary of operation
// - Two flow alarms flag flow outside range
// - Controller: suppress if setpoint outside or override
// - No-flow alarm below threshold, zero to 2%
// - Controller no-flow needs setpoint above threshold
// - Deviation outside percent limits longer than delay
// - Zero setpoint and flow alarms unless inhibited
// - Valve override suppresses deviation alarm
// - Temperature outside low/high limits alarms
// - Totalizer wrap latches overflow until host clears
// - Any supply out of limits alarms
// - Valve drive outside limits alarms
// - Calibration due at hours; clears on change
// - Overhaul hours count above 0.5% flow
// - Six stored pages, exactly one active
// - Aux voltage bands decode to pages
// - Most recent page selection wins
// - Page input must hold over three seconds
// - Invalid page: error bit, red LED, keep
// - Ramp off immediate, time mode percent/second
// - Analog setpoint below cutoff becomes zero
// - Flow below output cutoff reports zero
// - Totalizer saved every five seconds, restored
// - Latched alarm holds until cleared, relatches
// - Indicate highest code among active alarms
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "fasc_defines.svh"
module fasc_top #(
	parameter int unsigned TICK_CYCLES = `FASC_TICK_NS / `FASC_CLK_NS,
	parameter int unsigned HOUR_TICKS = `FASC_HOUR_S * `FASC_TICKS_PER_S
) (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [15:0] flow_i,
	input wire logic [15:0] sp_analog_i,
	input wire logic [15:0] temp_i,
	input wire logic [15:0] valve_drive_i,
	input wire logic [3:0] supply_fault_i,
	input wire logic valve_override_i,
	input wire logic [13:0] aux_input_reading_i,
	input wire logic nv_load_i,
	input wire logic [31:0] nv_total_i,
	output logic nv_wr_o,
	output logic [31:0] nv_total_o,
	output logic [15:0] flow_out_o,
	output logic [15:0] sp_eff_o,
	output logic [2:0] page_o,
	output logic module_state_led_red_o,
	output logic alarm_o,
	output logic [3:0] alarm_code_o
);
	localparam logic [15:0] SAVE_TICKS = 16'(`FASC_NV_SAVE_S * `FASC_TICKS_PER_S);
	localparam logic [9:0] SEC_TICKS = 10'(`FASC_TICKS_PER_S - 1);
	localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
	localparam logic [21:0] HOUR_LAST = 22'(HOUR_TICKS - 1);
	localparam logic [39:0] CODES = `FASC_ALARM_CODES;
	// ----------------------------------------
	// Reset release and time base
	// ----------------------------------------
	logic [1:0] rsync_q;
	logic rst_n;
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) rsync_q <= 2'h0;
		else rsync_q <= {rsync_q[0], 1'b1};
	end
	assign rst_n = rsync_q[1];
	logic [31:0] tick_cnt_q;
	logic tick_q;
	logic [9:0] sec_cnt_q;
	logic sec_q;
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_q <= 32'h00000000;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (tick_cnt_q == TICK_LAST);
			tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 32'h00000000 : tick_cnt_q + 32'h00000001;
		end
	end
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			sec_cnt_q <= 10'h000;
			sec_q <= 1'b0;
		end else begin
			sec_q <= tick_q && sec_cnt_q == SEC_TICKS;
			if (tick_q) sec_cnt_q <= (sec_cnt_q == SEC_TICKS) ? 10'h000 : sec_cnt_q + 10'h001;
		end
	end
	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	logic aw_full_q, w_full_q, wr_do;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	assign wr_do = aw_full_q && w_full_q && !s_axi_bvalid;
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			aw_full_q <= 1'b0;
			s_axi_awready <= 1'b1;
			awaddr_q <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_q <= 1'b1;
			s_axi_awready <= 1'b0;
			awaddr_q <= s_axi_awaddr;
		end else if (wr_do) begin
			aw_full_q <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			w_full_q <= 1'b0;
			s_axi_wready <= 1'b1;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_q <= 1'b1;
			s_axi_wready <= 1'b0;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (wr_do) begin
			w_full_q <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) if (s[b]) r[8*b +: 8] = d[8*b +: 8];
		return r;
	endfunction : merge
	function automatic logic mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= `FASC_REG_FLOW_SP;
	endfunction : mapped
	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic [3:0] ctrl_q;
	logic [9:0] alm_en_q, latch_en_q, alm_clr_q;
	fasc_pkg::fasc_lim_t flow1_q, flow2_q, temp_q, valve_q;
	logic [15:0] noflow_q;
	logic [31:0] dev_q, sp_q, cut_q;
	logic [15:0] hrs_set_q [2];
	logic [1:0] hrs_wr_q;
	logic [5:0] page_mask_q;
	logic ser_req_q;
	logic [2:0] ser_page_q;
	logic [31:0] wm;
	assign wm = merge(32'h00000000, wdata_q, wstrb_q);
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= 4'h0;
			alm_en_q <= `FASC_RST_ALM_EN;
			latch_en_q <= 10'h000;
			flow1_q <= `FASC_RST_FLOW1;
			flow2_q <= `FASC_RST_FLOW2;
			noflow_q <= `FASC_NOFLOW_MAX;
			dev_q <= `FASC_RST_DEV;
			temp_q <= `FASC_RST_TEMP;
			valve_q <= `FASC_RST_VALVE;
			hrs_set_q[0] <= `FASC_RST_HOURS;
			hrs_set_q[1] <= `FASC_RST_HOURS;
			sp_q <= 32'h00000000;
			cut_q <= 32'h00000000;
			page_mask_q <= 6'h3F;
		end else if (wr_do) begin
			unique case (awaddr_q)
				`FASC_REG_CTRL: ctrl_q <= 4'(merge({28'h0000000, ctrl_q}, wdata_q, wstrb_q));
				`FASC_REG_ALM_EN: alm_en_q <= 10'(merge({22'h000000, alm_en_q}, wdata_q, wstrb_q));
				`FASC_REG_LATCH_EN: latch_en_q <= 10'(merge({22'h000000, latch_en_q}, wdata_q,
					wstrb_q));
				`FASC_REG_FLOW1: flow1_q <= merge(flow1_q, wdata_q, wstrb_q);
				`FASC_REG_FLOW2: flow2_q <= merge(flow2_q, wdata_q, wstrb_q);
				`FASC_REG_NOFLOW: noflow_q <= 16'(merge({16'h0000, noflow_q}, wdata_q, wstrb_q));
				`FASC_REG_DEV: dev_q <= merge(dev_q, wdata_q, wstrb_q);
				`FASC_REG_TEMP: temp_q <= merge(temp_q, wdata_q, wstrb_q);
				`FASC_REG_VALVE: valve_q <= merge(valve_q, wdata_q, wstrb_q);
				`FASC_REG_CAL_HRS: hrs_set_q[0] <= 16'(merge({16'h0000, hrs_set_q[0]}, wdata_q,
					wstrb_q));
				`FASC_REG_OVH_HRS: hrs_set_q[1] <= 16'(merge({16'h0000, hrs_set_q[1]}, wdata_q,
					wstrb_q));
				`FASC_REG_SP: sp_q <= merge(sp_q, wdata_q, wstrb_q);
				`FASC_REG_CUTOFF: cut_q <= merge(cut_q, wdata_q, wstrb_q);
				`FASC_REG_PAGE_MASK: page_mask_q <= 6'(merge({26'h0000000, page_mask_q}, wdata_q,
					wstrb_q));
				default: ;
			endcase
		end
	end
	// Write pulses: alarm clear, hour setting change, serial page select
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			alm_clr_q <= 10'h000;
			hrs_wr_q <= 2'h0;
			ser_req_q <= 1'b0;
			ser_page_q <= 3'h0;
		end else begin
			alm_clr_q <= (wr_do && awaddr_q == `FASC_REG_ALM_CLR) ? wm[9:0] : 10'h000;
			hrs_wr_q <= {wr_do && awaddr_q == `FASC_REG_OVH_HRS,
				wr_do && awaddr_q == `FASC_REG_CAL_HRS};
			ser_req_q <= wr_do && awaddr_q == `FASC_REG_PAGE && wstrb_q[0];
			ser_page_q <= wm[2:0];
		end
	end
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else if (wr_do) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= mapped(awaddr_q) ? 2'h0 : 2'h2;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
	// ----------------------------------------
	// Setpoint conditioning and flow output
	// ----------------------------------------
	logic [15:0] sp_tgt, step;
	fasc_pkg::fasc_ramp_t ramp;
	assign ramp = fasc_pkg::fasc_ramp_t'(ctrl_q[`FASC_CTRL_RAMP]);
	assign step = sp_q[31:16];
	always_comb begin
		sp_tgt = sp_q[15:0];
		if (ctrl_q[`FASC_CTRL_SP_ANALOG])
			sp_tgt = (sp_analog_i < cut_q[15:0]) ? 16'h0000 : sp_analog_i;
	end
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			sp_eff_o <= 16'h0000;
		end else begin
			unique case (ramp)
				fasc_pkg::FASC_RAMP_OFF: sp_eff_o <= sp_tgt;
				fasc_pkg::FASC_RAMP_TIME: if (sec_q) begin
					if (sp_tgt > sp_eff_o)
						sp_eff_o <= (sp_tgt - sp_eff_o > step) ? sp_eff_o + step : sp_tgt;
					else
						sp_eff_o <= (sp_eff_o - sp_tgt > step) ? sp_eff_o - step : sp_tgt;
				end
			endcase
		end
	end
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) flow_out_o <= 16'h0000;
		else flow_out_o <= (flow_i < cut_q[31:16]) ? 16'h0000 : flow_i;
	end
	// ----------------------------------------
	// Totalizer with periodic save
	// ----------------------------------------
	logic [31:0] total_q;
	logic ovf_q;
	logic [15:0] save_cnt_q;
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			total_q <= 32'h00000000;
			ovf_q <= 1'b0;
		end else if (nv_load_i) begin
			total_q <= nv_total_i;
			ovf_q <= 1'b0;
		end else if (tick_q) begin
			{ovf_q, total_q} <= {1'b0, total_q} + {17'h00000, flow_out_o};
		end
	end
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			save_cnt_q <= 16'h0000;
			nv_wr_o <= 1'b0;
			nv_total_o <= 32'h00000000;
		end else begin
			nv_wr_o <= 1'b0;
			if (tick_q) begin
				save_cnt_q <= save_cnt_q + 16'h0001;
				if (save_cnt_q == SAVE_TICKS - 16'h0001) begin
					save_cnt_q <= 16'h0000;
					nv_wr_o <= 1'b1;
					nv_total_o <= total_q;
				end
			end
		end
	end
	// ----------------------------------------
	// Elapsed hours: calibration and overhaul
	// ----------------------------------------
	logic [1:0] hrs_run;
	logic [15:0] hrs_q [2];
	assign hrs_run = {flow_i > `FASC_OVH_FLOW_MIN, 1'b1};
	for (genvar h = 0; h < 2; h++) begin : g_hrs
		logic [21:0] sub_q;
		always_ff @(posedge clock_i or negedge rst_n) begin
			if (!rst_n) begin
				sub_q <= 22'h000000;
				hrs_q[h] <= 16'h0000;
			end else if (hrs_wr_q[h]) begin
				sub_q <= 22'h000000;
				hrs_q[h] <= 16'h0000;
			end else if (tick_q && hrs_run[h]) begin
				sub_q <= (sub_q == HOUR_LAST) ? 22'h000000 : sub_q + 22'h000001;
				if (sub_q == HOUR_LAST && hrs_q[h] != 16'hFFFF) hrs_q[h] <= hrs_q[h] + 16'h0001;
			end
		end
	end
	// ----------------------------------------
	// Alarm conditions, sampled each tick
	// ----------------------------------------
	logic [9:0] cond_q, cond, st_q;
	logic [15:0] nf_thr, sp;
	logic vor, ctl, dev_out;
	logic signed [33:0] dev_x, dev_lo, dev_hi;
	logic [15:0] dev_cnt_q;
	assign sp = sp_eff_o;
	assign vor = valve_override_i;
	assign ctl = ctrl_q[`FASC_CTRL_UNIT];
	assign nf_thr = (noflow_q > `FASC_NOFLOW_MAX) ? `FASC_NOFLOW_MAX : noflow_q;
	assign dev_x = 34'(($signed({1'b0, sp}) - $signed({1'b0, flow_i})) * 100);
	assign dev_lo = 34'($signed(dev_q[7:0])) * $signed({1'b0, sp});
	assign dev_hi = 34'($signed(dev_q[15:8])) * $signed({1'b0, sp});
	always_comb begin
		dev_out = dev_x < dev_lo || dev_x > dev_hi;
		if (sp == 16'h0000 && flow_i == 16'h0000)
			dev_out = !ctrl_q[`FASC_CTRL_ZSP_INH];
		cond = 10'h000;
		cond[0] = (flow_i < flow1_q.lo || flow_i > flow1_q.hi) &&
			!(ctl && (sp < flow1_q.lo || sp > flow1_q.hi || vor));
		cond[1] = (flow_i < flow2_q.lo || flow_i > flow2_q.hi) &&
			!(ctl && (sp < flow2_q.lo || sp > flow2_q.hi || vor));
		cond[2] = flow_i < nf_thr && !(ctl && (sp <= nf_thr || vor));
		cond[3] = dev_cnt_q > dev_q[31:16];
		cond[4] = temp_i < temp_q.lo || temp_i > temp_q.hi;
		cond[5] = ovf_q;
		cond[6] = |supply_fault_i;
		cond[7] = valve_drive_i < valve_q.lo || valve_drive_i > valve_q.hi;
		cond[8] = hrs_q[0] >= hrs_set_q[0];
		cond[9] = hrs_q[1] >= hrs_set_q[1];
	end
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			dev_cnt_q <= 16'h0000;
			cond_q <= 10'h000;
		end else if (tick_q) begin
			cond_q <= cond & alm_en_q;
			if (!dev_out || vor) dev_cnt_q <= 16'h0000;
			else if (dev_cnt_q != 16'hFFFF) dev_cnt_q <= dev_cnt_q + 16'h0001;
		end
	end
	// Set beats clear, so a still-present condition relatches at once
	for (genvar i = 0; i < `FASC_NALM; i++) begin : g_alm
		always_ff @(posedge clock_i or negedge rst_n) begin
			if (!rst_n) st_q[i] <= 1'b0;
			else if (!alm_en_q[i]) st_q[i] <= 1'b0;
			else if (latch_en_q[i] || i == `FASC_ALM_OVF)
				st_q[i] <= cond_q[i] | (st_q[i] & ~alm_clr_q[i]);
			else st_q[i] <= cond_q[i];
		end
	end
	logic [3:0] top_code;
	always_comb begin
		top_code = 4'h0;
		for (int i = 0; i < `FASC_NALM; i++)
			if (st_q[i] && CODES[4*i +: 4] > top_code) top_code = CODES[4*i +: 4];
	end
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			alarm_o <= 1'b0;
			alarm_code_o <= 4'h0;
		end else begin
			alarm_o <= |st_q;
			alarm_code_o <= top_code;
		end
	end
	// ----------------------------------------
	// Calibration page selection
	// ----------------------------------------
	logic aux_req;
	logic [2:0] aux_page, req_page;
	logic page_err_q;
	fasc_page_sel u_page (
		.clk_i(clock_i),
		.rst_n_i(rst_n),
		.tick_i(tick_q),
		.aux_mv_i(aux_input_reading_i),
		.req_o(aux_req),
		.page_o(aux_page)
	);
	// A serial select in the same cycle counts as the later one
	assign req_page = ser_req_q ? ser_page_q : aux_page;
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			page_o <= `FASC_RST_PAGE;
			page_err_q <= 1'b0;
			module_state_led_red_o <= 1'b0;
		end else begin
			module_state_led_red_o <= page_err_q;
			if (ser_req_q || aux_req) begin
				if (req_page != 3'h0 && req_page <= `FASC_NPAGE && page_mask_q[req_page - 3'h1]) begin
					page_o <= req_page;
					page_err_q <= 1'b0;
				end else begin
					page_err_q <= 1'b1;
				end
			end
		end
	end
	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [31:0] rd;
	always_comb begin
		unique case (s_axi_araddr)
			`FASC_REG_CTRL: rd = {28'h0000000, ctrl_q};
			`FASC_REG_ALM_EN: rd = {22'h000000, alm_en_q};
			`FASC_REG_LATCH_EN: rd = {22'h000000, latch_en_q};
			`FASC_REG_FLOW1: rd = flow1_q;
			`FASC_REG_FLOW2: rd = flow2_q;
			`FASC_REG_NOFLOW: rd = {16'h0000, noflow_q};
			`FASC_REG_DEV: rd = dev_q;
			`FASC_REG_TEMP: rd = temp_q;
			`FASC_REG_VALVE: rd = valve_q;
			`FASC_REG_CAL_HRS: rd = {hrs_q[0], hrs_set_q[0]};
			`FASC_REG_OVH_HRS: rd = {hrs_q[1], hrs_set_q[1]};
			`FASC_REG_SP: rd = sp_q;
			`FASC_REG_CUTOFF: rd = cut_q;
			`FASC_REG_PAGE: rd = {29'h00000000, page_o};
			`FASC_REG_PAGE_MASK: rd = {26'h0000000, page_mask_q};
			`FASC_REG_STATUS: rd = {5'h00, page_o, 4'h0, alarm_code_o, 6'h00, st_q};
			`FASC_REG_EXT_ERR: rd = page_err_q ? `FASC_EXT_ERR_PAGE : 32'h00000000;
			`FASC_REG_TOTAL: rd = total_q;
			`FASC_REG_FLOW_SP: rd = {sp_eff_o, flow_out_o};
			default: rd = 32'h00000000;
		endcase
	end
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd;
			s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule : fasc_top
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the flow alarm block
`timescale 1ns/100ps
`default_nettype none
`include "fasc_defines.svh"
module testbench;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [7:0] addr;
	logic [31:0] wdat, rdat;
	logic awv, awr, wv, wrdy, bv, bry, arv, arr, rv, rry, ovr = 1'b0, nv_ld = 1'b0;
	logic [1:0] bresp, rresp;
	logic [15:0] flow = 16'h0000, flow_out, sp_eff;
	logic [13:0] aux = 14'h0000;
	logic [31:0] nv_tot = 32'h00000000;
	logic [2:0] page;
	logic red, alarm;
	logic [3:0] code, sf = 4'h0;
	int failures = 0;
	int n_compared = 0;
	fasc_top #(.TICK_CYCLES(10), .HOUR_TICKS(20)) dut (.clock_i, .nrst_i, .s_axi_awaddr(addr),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdat), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(addr), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.flow_i(flow), .sp_analog_i(flow), .temp_i(16'h0010), .valve_drive_i(flow),
		.supply_fault_i(sf), .valve_override_i(ovr), .aux_input_reading_i(aux),
		.nv_load_i(nv_ld), .nv_total_i(nv_tot), .nv_wr_o(), .nv_total_o(),
		.flow_out_o(flow_out), .sp_eff_o(sp_eff), .page_o(page), .module_state_led_red_o(red),
		.alarm_o(alarm), .alarm_code_o(code));
	fasc_host_model host (.clk_i(clock_i), .addr_o(addr), .data_o(wdat), .awv_o(awv),
		.wv_o(wv), .bry_o(bry), .arv_o(arv), .rry_o(rry), .awr_i(awr), .wr_i(wrdy), .bv_i(bv),
		.br_i(bresp), .arr_i(arr), .rv_i(rv), .rd_i(rdat), .rr_i(rresp));
	initial forever #2 clock_i = ~clock_i;
	task automatic stop_test(input int t);
		failures += t;
		if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic idle(input int c);
		repeat (c) @(posedge clock_i);
	endtask : idle
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic [1:0] r;
		host.acc(1'b1, a, d, r);
		chk("bresp", {30'h0, e}, {30'h0, r});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		host.acc(1'b0, a, d, r);
		chk("rdata", e, d);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask : rd
	task automatic t_regs;
		rd(`FASC_REG_ALM_EN, 32'h000003FF, 2'b00);
		rd(`FASC_REG_FLOW1, `FASC_RST_FLOW1, 2'b00);
		rd(8'h50, 32'h00000000, 2'b10);
		wr(8'h50, 32'h00000001, 2'b10);
	endtask : t_regs
	task automatic t_flow;
		wr(`FASC_REG_ALM_EN, 32'h00000001, 2'b00);
		flow <= 16'h2711;
		idle(40);
		chk("code", 32'hB, {28'h0, code});
		wr(`FASC_REG_CTRL, 32'h00000001, 2'b00);
		ovr <= 1'b1;
		idle(40);
		chk("code", 32'h0, {28'h0, code});
		ovr <= 1'b0;
		idle(40);
		chk("code", 32'hB, {28'h0, code});
		wr(`FASC_REG_FLOW1, 32'h27100064, 2'b00);
		idle(40);
		chk("code", 32'h0, {28'h0, code});
		wr(`FASC_REG_CTRL, 32'h00000000, 2'b00);
	endtask : t_flow
	task automatic t_cut;
		wr(`FASC_REG_CUTOFF, 32'h00640064, 2'b00);
		wr(`FASC_REG_SP, 32'h00000BB8, 2'b00);
		flow <= 16'h0063;
		idle(40);
		chk("flow_out", 32'h0, {16'h0, flow_out});
		chk("sp_eff", 32'hBB8, {16'h0, sp_eff});
		flow <= 16'h0096;
		idle(40);
		chk("flow_out", 32'h96, {16'h0, flow_out});
		wr(`FASC_REG_CTRL, 32'h00000008, 2'b00);
		flow <= 16'h0063;
		idle(4);
		chk("sp_eff", 32'h0, {16'h0, sp_eff});
	endtask : t_cut
	task automatic t_ovf;
		wr(`FASC_REG_ALM_EN, 32'h000000E0, 2'b00);
		flow <= 16'h2710;
		nv_tot <= 32'hFFFFFF00;
		nv_ld <= 1'b1;
		@(posedge clock_i);
		nv_ld <= 1'b0;
		idle(40);
		chk("code", 32'h7, {28'h0, code});
		flow <= 16'h0000;
		idle(40);
		chk("code", 32'h7, {28'h0, code});
		wr(`FASC_REG_ALM_CLR, 32'h00000020, 2'b00);
		idle(40);
		chk("alarm", 32'h0, {31'h0, alarm});
	endtask : t_ovf
	task automatic t_page;
		int n;
		wr(`FASC_REG_PAGE, 32'h00000007, 2'b00);
		idle(10);
		chk("page", 32'h1, {29'h0, page});
		chk("led", 32'h1, {31'h0, red});
		rd(`FASC_REG_EXT_ERR, `FASC_EXT_ERR_PAGE, 2'b00);
		wr(`FASC_REG_PAGE, 32'h00000003, 2'b00);
		idle(10);
		chk("page", 32'h3, {29'h0, page});
		chk("led", 32'h0, {31'h0, red});
		sf <= 4'h4;
		aux <= 14'h125C;
		idle(29000);
		chk("page", 32'h3, {29'h0, page});
		chk("code", 32'h6, {28'h0, code});
		for (n = 0; n < 3000 && page !== 3'h6; n++) idle(1);
		chk("page", 32'h6, {29'h0, page});
	endtask : t_page
	initial begin
		repeat (6) @(posedge clock_i);
		nrst_i <= 1'b1;
		idle(4);
		t_regs();
		t_flow();
		t_cut();
		t_ovf();
		t_page();
		stop_test(0);
	end
endmodule : testbench
bind fasc_top fasc_properties #(.TICK_CYCLES(TICK_CYCLES), .HOUR_TICKS(HOUR_TICKS)) props (
	.clock_i, .nrst_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .nv_wr_o, .page_o, .alarm_o, .alarm_code_o);
`default_nettype wire
